// [bench/odp_product_one_tb.sv]
// self-checking bench for the product-one selector
`timescale 1ns/100ps
module odp_product_one_tb;
   import odp_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [24:0] good = 25'h1ffffff;
   logic manualReset_n = 1'b1;
   logic productTwoTrue = 1'b0;
   logic productOneTrue;
   logic sequencerOutputFour;
   logic [7:0] selAddr [4] = '{8'h1d, 8'h1e, 8'h1f, 8'h23};
   int n_fail = 0;
   int tests_run = 0;

   odp_product_one #(.VARIANT(ODP_VARIANT_LARGE)) i_odp_product_one (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .regWrEn(regWrEn),
      .regRdEn(regRdEn),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .regRdValid(regRdValid),
      .primaryGood(good[5:0]),
      .watchdogGood(good[7:6]),
      .secondaryGood(good[13:8]),
      .logicInput(good[17:14]),
      .otherOutputsAsserted(~good[24:18]),
      .manual_reset_n(manualReset_n),
      .productTwoTrue(productTwoTrue),
      .productOneTrue(productOneTrue),
      .sequencerOutputFour(sequencerOutputFour)
   );

   always #20 sys_clk = ~sys_clk;

   task wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one-cycle write strobe, launched on the falling edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge sys_clk);
      regWrEn = 1'b0;
   endtask : wr

   // read with a bounded wait for the valid pulse
   task rd(input logic [7:0] a, input logic [7:0] exp);
      int i;
      @(negedge sys_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge sys_clk);
      regRdEn = 1'b0;
      for (i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      if (regRdValid !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t no read answer", $time);
         wrap_up();
      end
      check(regRdData, exp);
   endtask : rd

   // let inputs propagate, then compare term and output
   task settle(input logic t, input logic o);
      repeat (2) @(negedge sys_clk);
      check({7'h00, productOneTrue}, {7'h00, t});
      check({7'h00, sequencerOutputFour}, {7'h00, o});
   endtask : settle

   initial begin
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      foreach (selAddr[j]) rd(selAddr[j], 8'h00);
      rd(8'h40, 8'h00);
      good = 25'h0;
      settle(1'b1, 1'b0);
      // each condition alone: others faulted but ignored, then itself
      for (int k = 0; k < 25; k++) begin
         wr(selAddr[k/8], 8'h01 << (k % 8));
         rd(selAddr[k/8], 8'h01 << (k % 8));
         good = 25'h0;
         good[k] = 1'b1;
         settle(1'b1, 1'b0);
         good[k] = 1'b0;
         settle(1'b0, 1'b1);
         wr(selAddr[k/8], 8'h00);
      end
      good = 25'h1ffffff;
      wr(8'h1d, 8'h01);
      productTwoTrue = 1'b1;
      settle(1'b1, 1'b0);
      good[0] = 1'b0;
      settle(1'b0, 1'b0);
      productTwoTrue = 1'b0;
      settle(1'b0, 1'b1);
      good[0] = 1'b1;
      wr(8'h40, 8'h08);
      manualReset_n = 1'b0;
      settle(1'b1, 1'b1);
      rd(8'h40, 8'h08);
      wr(8'h40, 8'h04);
      settle(1'b1, 1'b0);
      wr(8'h40, 8'h08);
      manualReset_n = 1'b1;
      settle(1'b1, 1'b0);
      wr(8'h41, 8'hff);
      wr(8'h20, 8'hff);
      rd(8'h41, 8'h00);
      rd(8'h1d, 8'h01);
      // mid-run reset clears the selections
      reset_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({7'h00, productOneTrue}, 8'h00);
      check({7'h00, sequencerOutputFour}, 8'h01);
      reset_n = 1'b1;
      rd(8'h1d, 8'h00);
      rd(8'h40, 8'h00);
      settle(1'b1, 1'b0);
      wrap_up();
   end
endmodule : odp_product_one_tb

// [hw/odp_params.svh]
// constants for the first product term of sequencer output four
`ifndef ODP_PARAMS_SVH
`define ODP_PARAMS_SVH

`define ODP_ADDR_SEL_PRIMARY 8'h1d
`define ODP_ADDR_SEL_SECONDARY 8'h1e
`define ODP_ADDR_SEL_OUTPUTS 8'h1f
`define ODP_ADDR_SEL_LAST 8'h23
`define ODP_ADDR_MR_ROUTING 8'h40

`define ODP_SEL_RESET 8'h00
`define ODP_RD_UNMAPPED 8'h00

`define ODP_MR_ROUTE_BIT 3
`define ODP_LAST_OUT_BIT 0

`define ODP_PRIMARY_LARGE_MASK 8'h30
`define ODP_SECONDARY_LARGE_MASK 8'h30
`define ODP_OUTPUTS_LARGE_MASK 8'h0c
`define ODP_LAST_LARGE_MASK 8'h01

`define ODP_COND_WIDTH 25

`endif

// [hw/odp_pkg.sv]
// types shared by the product-one selector
package odp_pkg;
   typedef logic [7:0] odp_byte_t;
   typedef enum {ODP_VARIANT_SMALL, ODP_VARIANT_LARGE} odp_variant_t;
endpackage : odp_pkg

// [hw/odp_product_one.sv]
// selector and decision for sequencer output four, product term one
`timescale 1ns/100ps
`include "odp_params.svh"
module odp_product_one
   import odp_pkg::*;
#(
   parameter odp_variant_t VARIANT = ODP_VARIANT_LARGE
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic [5:0] primaryGood,
   input wire logic [5:0] secondaryGood,
   input wire logic [1:0] watchdogGood,
   input wire logic [3:0] logicInput,
   input wire logic [6:0] otherOutputsAsserted,
   input wire logic manual_reset_n,
   input wire logic productTwoTrue,
   output logic productOneTrue,
   output logic sequencerOutputFour
);
   odp_byte_t selPrimary;
   odp_byte_t selSecondary;
   odp_byte_t selOutputs;
   odp_byte_t selLast;
   odp_byte_t mrRouting;

   odp_byte_t effPrimary;
   odp_byte_t effSecondary;
   odp_byte_t effOutputs;
   logic effLast;
   logic isSmall;

   logic [`ODP_COND_WIDTH-1:0] condSelect;
   logic [`ODP_COND_WIDTH-1:0] condGood;
   logic termOne;
   logic mrForce;
   logic next_sequencerOutputFour;

   assign isSmall = (VARIANT == ODP_VARIANT_SMALL);

   // register writes from the configuration port
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         selPrimary <= `ODP_SEL_RESET;
         selSecondary <= `ODP_SEL_RESET;
         selOutputs <= `ODP_SEL_RESET;
         selLast <= `ODP_SEL_RESET;
         mrRouting <= `ODP_SEL_RESET;
      end else if (regWrEn) begin
         unique case (regAddr)
            `ODP_ADDR_SEL_PRIMARY: begin
               selPrimary <= regWrData;
            end
            `ODP_ADDR_SEL_SECONDARY: begin
               selSecondary <= regWrData;
            end
            `ODP_ADDR_SEL_OUTPUTS: begin
               selOutputs <= regWrData;
            end
            `ODP_ADDR_SEL_LAST: begin
               selLast <= regWrData;
            end
            `ODP_ADDR_MR_ROUTING: begin
               mrRouting <= regWrData;
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
   end

   // register reads, answered one cycle later
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         regRdData <= `ODP_RD_UNMAPPED;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            unique case (regAddr)
               `ODP_ADDR_SEL_PRIMARY: begin
                  regRdData <= selPrimary;
               end
               `ODP_ADDR_SEL_SECONDARY: begin
                  regRdData <= selSecondary;
               end
               `ODP_ADDR_SEL_OUTPUTS: begin
                  regRdData <= selOutputs;
               end
               `ODP_ADDR_SEL_LAST: begin
                  regRdData <= selLast;
               end
               `ODP_ADDR_MR_ROUTING: begin
                  regRdData <= mrRouting;
               end
               default: begin
                  regRdData <= `ODP_RD_UNMAPPED;
               end
            endcase
         end
      end
   end

   // large-only selections are dropped on the small variant
   always_comb begin
      effPrimary = selPrimary;
      effSecondary = selSecondary;
      effOutputs = selOutputs;
      effLast = selLast[`ODP_LAST_OUT_BIT];
      if (isSmall) begin
         effPrimary = selPrimary & ~`ODP_PRIMARY_LARGE_MASK;
         effSecondary = selSecondary & ~`ODP_SECONDARY_LARGE_MASK;
         effOutputs = selOutputs & ~`ODP_OUTPUTS_LARGE_MASK;
         effLast = 1'b0;
      end
   end

   // condition vector in register bit order
   assign condSelect = {effLast, effOutputs, effSecondary, effPrimary};

   assign condGood[5:0] = primaryGood;
   assign condGood[7:6] = watchdogGood;
   assign condGood[13:8] = secondaryGood;
   assign condGood[15:14] = logicInput[1:0];
   assign condGood[17:16] = logicInput[3:2];
   assign condGood[19:18] = ~otherOutputsAsserted[1:0];
   assign condGood[23:20] = ~otherOutputsAsserted[5:2];
   assign condGood[24] = ~otherOutputsAsserted[6];

   odp_term_eval u_term_one (
      .condSelect(condSelect),
      .condGood(condGood),
      .termTrue(termOne)
   );

   assign mrForce = mrRouting[`ODP_MR_ROUTE_BIT] & ~manual_reset_n;

   always_comb begin
      next_sequencerOutputFour = ~(termOne | productTwoTrue);
      if (mrForce) begin
         next_sequencerOutputFour = 1'b1;
      end
   end

   // registered decision
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sequencerOutputFour <= 1'b1;
         productOneTrue <= 1'b0;
      end else begin
         sequencerOutputFour <= next_sequencerOutputFour;
         productOneTrue <= termOne;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   sequence mrHeldLow;
      mrRouting[`ODP_MR_ROUTE_BIT] && !manual_reset_n;
   endsequence

   sequence termFires;
      !mrForce && (termOne || productTwoTrue);
   endsequence

   sequence allQuiet;
      !mrForce && !termOne && !productTwoTrue;
   endsequence

   sequence writePrimary;
      regWrEn && regAddr == `ODP_ADDR_SEL_PRIMARY;
   endsequence

   sequence writeUnmapped;
      regWrEn && regAddr != `ODP_ADDR_SEL_PRIMARY
      && regAddr != `ODP_ADDR_SEL_SECONDARY
      && regAddr != `ODP_ADDR_SEL_OUTPUTS
      && regAddr != `ODP_ADDR_SEL_LAST
      && regAddr != `ODP_ADDR_MR_ROUTING;
   endsequence

   primary_fault_a: assert property (
      effPrimary[0] && !primaryGood[0] |=> !productOneTrue)
      else $error("primary fault did not clear product one");

   chan_four_a: assert property (
      effPrimary[3] && !primaryGood[3] |=> !productOneTrue)
      else $error("channel four primary fault ignored");

   large_chan_a: assert property (
      !isSmall && selPrimary[5] && !primaryGood[5] |=> !productOneTrue)
      else $error("channel six primary fault ignored on large variant");

   small_masked_a: assert property (
      isSmall |-> effPrimary[5:4] == 2'b00 && effSecondary[5:4] == 2'b00)
      else $error("large-only channel bits active on small variant");

   watchdog_dep_a: assert property (
      selPrimary[7] && !watchdogGood[1] |=> !productOneTrue)
      else $error("watchdog two fault ignored");

   watchdog_one_a: assert property (
      selPrimary[6] && !watchdogGood[0] |=> !productOneTrue)
      else $error("watchdog one fault ignored");

   secondary_dep_a: assert property (
      selSecondary[2] && !secondaryGood[2] |=> !productOneTrue)
      else $error("secondary threshold fault ignored");

   large_secondary_a: assert property (
      !isSmall && selSecondary[4] && !secondaryGood[4] |=> !productOneTrue)
      else $error("channel five secondary fault ignored");

   logic_input_a: assert property (
      selOutputs[1] && !logicInput[3] |=> !productOneTrue)
      else $error("logic input four ignored");

   logic_one_a: assert property (
      selSecondary[6] && !logicInput[0] |=> !productOneTrue)
      else $error("logic input one ignored");

   logic_three_a: assert property (
      selOutputs[0] && !logicInput[2] |=> !productOneTrue)
      else $error("logic input three ignored");

   outputs_small_a: assert property (
      isSmall |-> effOutputs[3:2] == 2'b00 && !effLast)
      else $error("large-only output bits active on small variant");

   output_one_a: assert property (
      !isSmall && selOutputs[2] && otherOutputsAsserted[0]
      |=> !productOneTrue)
      else $error("sequencer output one dependency ignored");

   other_output_a: assert property (
      selOutputs[4] && otherOutputsAsserted[2] |=> !productOneTrue)
      else $error("sequencer output three dependency ignored");

   output_five_a: assert property (
      selOutputs[5] && otherOutputsAsserted[3] |=> !productOneTrue)
      else $error("sequencer output five dependency ignored");

   output_seven_a: assert property (
      selOutputs[7] && otherOutputsAsserted[5] |=> !productOneTrue)
      else $error("sequencer output seven dependency ignored");

   last_output_a: assert property (
      effLast && otherOutputsAsserted[6] |=> !productOneTrue)
      else $error("sequencer output eight dependency ignored");

   mr_force_a: assert property (
      mrHeldLow |=> sequencerOutputFour)
      else $error("manual reset did not assert output");

   mr_route_off_a: assert property (
      !mrRouting[`ODP_MR_ROUTE_BIT] && (termOne || productTwoTrue)
      |=> !sequencerOutputFour)
      else $error("manual reset forced output without routing bit");

   unselected_a: assert property (
      condSelect == '0 |=> productOneTrue)
      else $error("empty selection did not give a true term");

   ignored_fault_a: assert property (
      condSelect == 25'h0000001 && primaryGood[0] |=> productOneTrue)
      else $error("unselected fault reached product one");

   term_deassert_a: assert property (
      termFires |=> !sequencerOutputFour)
      else $error("output stayed asserted with a true term");

   quiet_assert_a: assert property (
      allQuiet [*2] |=> sequencerOutputFour [*1])
      else $error("output not asserted with both terms false");

   term_and_a: assert property (
      &primaryGood && &secondaryGood && &watchdogGood && &logicInput
      && otherOutputsAsserted == 7'h00 |=> productOneTrue)
      else $error("product one false with all conditions good");

   write_store_a: assert property (
      writePrimary |=> selPrimary == $past(regWrData))
      else $error("primary selection write not stored");

   read_answer_a: assert property (
      regRdEn && regAddr == `ODP_ADDR_MR_ROUTING
      |=> regRdValid && regRdData == $past(mrRouting))
      else $error("routing register read answer wrong");

   read_pulse_a: assert property (
      !regRdEn |=> !regRdValid)
      else $error("read valid without a read strobe");

   write_drop_a: assert property (
      writeUnmapped |=> $stable(selPrimary) && $stable(selSecondary)
      && $stable(selOutputs) && $stable(selLast) && $stable(mrRouting))
      else $error("unmapped write changed a selection register");

endmodule : odp_product_one

// [hw/odp_term_eval.sv]
// one product term: and of good states over selected conditions
`timescale 1ns/100ps
`include "odp_params.svh"
module odp_term_eval
   import odp_pkg::*;
(
   input wire logic [`ODP_COND_WIDTH-1:0] condSelect,
   input wire logic [`ODP_COND_WIDTH-1:0] condGood,
   output logic termTrue
);
   logic [`ODP_COND_WIDTH-1:0] passBit;

   genvar i;
   generate
      for (i = 0; i < `ODP_COND_WIDTH; i++) begin : g_cond
         // unselected bit passes as 1
         assign passBit[i] = condGood[i] | ~condSelect[i];
      end
   endgenerate

   assign termTrue = &passBit;
endmodule : odp_term_eval
